/* File: logic/fsh_pkg.sv */
// Constants and carriers for the flash self-programming sequencer.
// Assumes a 10 MHz core clock and a 64-word page, 512-page flash.
package fsh_pkg;

	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [7:0] ADDR_CTRL  = 8'h00; // Control and status
	localparam logic [7:0] ADDR_PTR   = 8'h04; // 16-bit address pointer
	localparam logic [7:0] ADDR_DATA  = 8'h08; // Data pair, high byte on 15:8
	localparam logic [7:0] ADDR_STORE = 8'h0C; // Store strobe, any write
	localparam logic [7:0] ADDR_READ  = 8'h10; // Program byte read
	localparam logic [7:0] ADDR_LOCK  = 8'h14; // Lock bits readback
	localparam logic [7:0] ADDR_STAT  = 8'h18; // Block status

	// ****************************************
	// Control fields and command patterns
	// ****************************************
	localparam int         CB_EN    = 0;     // Command enable
	localparam int         CB_BUSY  = 6;     // Area busy flag
	localparam int         CB_IE    = 7;     // Completion interrupt enable
	localparam logic [5:0] CMD_LOAD = 6'h01; // Buffer word load
	localparam logic [5:0] CMD_ERAS = 6'h03; // Page erase
	localparam logic [5:0] CMD_WRIT = 6'h05; // Page write
	localparam logic [5:0] CMD_LOCK = 6'h09; // Lock bit set
	localparam logic [5:0] CMD_REEN = 6'h11; // Area re-enable

	// ****************************************
	// Status fields
	// ****************************************
	localparam int ST_EE   = 0;  // EEPROM write in progress
	localparam int ST_OP   = 1;  // Operation running
	localparam int ST_HALT = 2;  // Processor halted
	localparam int ST_FUSE = 3;  // Boot vector fuse level
	localparam int ST_VEC  = 16; // Reset vector word address, 15 bits

	// ****************************************
	// Flash geometry
	// ****************************************
	localparam int          WORD_LSB   = 1;        // Word field low bit
	localparam int          WORD_W     = 6;        // Word field width
	localparam int          PAGE_LSB   = 7;        // Page field low bit
	localparam int          PAGE_W     = 9;        // Page field width
	localparam int          PAGE_WORDS = 64;       // Words per page
	localparam logic [8:0]  NO_READWHILEWRITE_AREA_PAGE  = 9'h1C0;   // First protected-read page
	localparam logic [8:0]  BOOT_PAGE  = 9'h1F0;   // First boot loader page
	localparam logic [14:0] APP_VEC    = 15'h0000; // Application reset word
	localparam logic [14:0] BOOT_VEC   = 15'h7C00; // Boot loader reset word

	// ****************************************
	// Values and timing
	// ****************************************
	localparam logic [5:0]  LOCK_RST  = 6'h3F;   // All lock bits unprogrammed
	localparam logic [15:0] ERASED    = 16'hFFFF; // Unloaded buffer word
	localparam logic [7:0]  BLOCKED   = 8'hFF;   // Read of a blocked area
	localparam logic [2:0]  STORE_WIN = 3'h4;    // Store window in cycles
	localparam logic [1:0]  RESP_OK   = 2'h0;    // AXI OKAY
	localparam logic [1:0]  RESP_ERR  = 2'h2;    // AXI SLVERR
	localparam int          CLK_MHZ   = 10;      // Core clock rate
	localparam int          PROG_US   = 3700;    // Least programming time
	localparam int          PROG_CYC  = PROG_US * CLK_MHZ; // Cycles, exact

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic        en;   // Word write strobe
		logic [14:0] addr; // Flash word address
		logic [15:0] data; // Word to program
	} fsh_wr_s;

	typedef struct packed {
		logic       en;   // Erase strobe
		logic [8:0] page; // Page to erase
	} fsh_er_s;

endpackage

/* File: logic/fsh_sequencer.sv */
// Flash self-programming sequencer with AXI4-Lite register access.
// Assumes flash_rd_data follows flash_rd_addr one cycle later and that
// the flash array and EEPROM controller sit outside this block.
//
// Function
// - Reset vector chosen by boot fuse
// - Fuses never written by the processor
// - Pointer bits select page and word
// - Target address latched at operation start
// - Lock set ignores the pointer
// - Pointer bit 0 selects read byte
// - Buffer loads accepted in any order
// - Erase pattern plus store erases page
// - Halt processor for protected area targets
// - Load pattern plus store fills buffer word
// - Buffer cleared on write, re-enable, reset
// - EEPROM write discards loaded buffer words
// - Write pattern plus store writes page
// - Interrupt level while command enable clear
// - Erase or write blocks area, busy set
// - Busy stays until re-enable is written
// - Lock set programs zero bits of data
// - Lock programming blocks and halts nothing
// - EEPROM busy refuses commands, lock reads
// - Lock bits cleared only by chip erase or reset
// - Locked application area rejects stores
//
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module fsh_sequencer
	import fsh_pkg::*;
#(
	parameter int PROG_CYCLES = PROG_CYC // Programming time in cycles
)(
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write channels
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// AXI4-Lite read channels
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// Pins from outside the clock domain
	input  wire logic        boot_vector_fuse,
	input  wire logic        eeprom_write_in_progress_flag,
	input  wire logic        chip_erase_req,
	// Flash array
	input  wire logic [15:0] flash_rd_data,
	output logic [14:0]      flash_rd_addr,
	output fsh_wr_s          flash_wr,
	output fsh_er_s          flash_erase,
	// Core side
	output logic [14:0]      reset_vector,
	output logic             cpu_halt,
	output logic             rww_read_block,
	output logic             spm_irq
);

	// ****************************************
	// Declarations
	// ****************************************
	typedef enum logic [1:0] {S_IDLE, S_ERASE, S_WRITE, S_LOCK} fsh_state_e;

	fsh_state_e  state_q;                  // Operation state
	logic [31:0] tmr_q;                    // Operation timer
	logic [4:0]  cmd_q;                    // Command bits of control
	logic        ie_q;                     // Interrupt enable
	logic        busy_q;                   // Area busy flag
	logic        halt_q;                   // Target is protected area
	logic [2:0]  win_q;                    // Store window count
	logic [8:0]  page_q;                   // Latched page
	logic [5:0]  lkdat_q;                  // Latched lock data
	logic [5:0]  lock_q;                   // Lock bits
	logic [15:0] ptr_q;                    // Address pointer
	logic [15:0] dat_q;                    // Data pair
	logic [15:0] buf_q [0:PAGE_WORDS-1];   // Temporary page buffer
	logic [63:0] bval_q;                   // Buffer word loaded flags
	logic        strm_q;                   // Write stream active
	logic [5:0]  idx_q;                    // Write stream index
	logic        ee_s1, ee_s2;             // EEPROM flag synchroniser
	logic        fu_s1, fu_s2;             // Fuse synchroniser
	logic        ce_s1, ce_s2;             // Chip erase synchroniser
	logic        wr_take, rd_take;         // Bus transfers this edge
	logic        ctrl_wr, store_wr;        // Decoded writes
	logic        go;                       // Store within window
	logic        op_done;                  // Last cycle of operation
	logic [5:0]  cmd6;                     // Full command pattern
	logic        ld_go, clr_buf, wr_start; // Buffer events
	logic        permit;                   // Target area not locked
	logic [31:0] rd_mux;                   // Read data
	logic [1:0]  rd_resp;                  // Read response

	// ****************************************
	// Functions
	// ****************************************
	// Merge written bytes into a 16-bit register
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] nw, input logic [3:0] st);
		merge16 = old;
		if (st[0])
			merge16[7:0] = nw[7:0];
		if (st[1])
			merge16[15:8] = nw[15:8];
	endfunction

	// Mapped register check
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a <= ADDR_STAT) && (a[1:0] == 2'h0);
	endfunction

	// Page lies in the protected-read area
	function automatic logic in_no_readwhilewrite_area(input logic [8:0] p);
		in_no_readwhilewrite_area = (p >= NO_READWHILEWRITE_AREA_PAGE);
	endfunction

	// Page lies in the boot loader area
	function automatic logic in_boot(input logic [8:0] p);
		in_boot = (p >= BOOT_PAGE);
	endfunction

	// ****************************************
	// Synchronisers
	// ****************************************
	// Two flip-flops for each pin
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			{ee_s1, ee_s2} <= 2'h0;
			{fu_s1, fu_s2} <= 2'h3;
			{ce_s1, ce_s2} <= 2'h0;
		end
		else
		begin
			ee_s1 <= eeprom_write_in_progress_flag;
			ee_s2 <= ee_s1;
			fu_s1 <= boot_vector_fuse;
			fu_s2 <= fu_s1;
			ce_s1 <= chip_erase_req;
			ce_s2 <= ce_s1;
		end
	end

	// ****************************************
	// AXI4-Lite slave
	// ****************************************
	assign wr_take  = awready;
	assign rd_take  = arready;
	assign ctrl_wr  = wr_take && (awaddr == ADDR_CTRL);
	assign store_wr = wr_take && (awaddr == ADDR_STORE);

	// Write channels: address and data taken together, then response
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready <= 1'b0;
			wready  <= 1'b0;
			bvalid  <= 1'b0;
			bresp   <= RESP_OK;
		end
		else
		begin
			awready <= awvalid && wvalid && !awready && !bvalid;
			wready  <= awvalid && wvalid && !awready && !bvalid;
			if (wr_take)
			begin
				bvalid <= 1'b1;
				bresp  <= mapped(awaddr) ? RESP_OK : RESP_ERR;
			end
			else if (bready)
				bvalid <= 1'b0;
		end
	end

	// Read data selection
	always_comb
	begin
		rd_mux  = 32'h0;
		rd_resp = mapped(araddr) ? RESP_OK : RESP_ERR;
		unique case (araddr)
			ADDR_CTRL: rd_mux[7:0] = {ie_q, busy_q, 1'b0, cmd_q};
			ADDR_PTR:  rd_mux[15:0] = ptr_q;
			ADDR_DATA: rd_mux[15:0] = dat_q;
			ADDR_READ:
			begin
				if (busy_q && !in_no_readwhilewrite_area(ptr_q[15:PAGE_LSB]))
					rd_mux[7:0] = BLOCKED;
				else
					rd_mux[7:0] = ptr_q[0] ? flash_rd_data[15:8] : flash_rd_data[7:0];
			end
			ADDR_LOCK:
			begin
				if (ee_s2)
					rd_resp = RESP_ERR;
				else
					rd_mux[7:0] = {2'h3, lock_q};
			end
			ADDR_STAT:
			begin
				rd_mux[ST_EE]   = ee_s2;
				rd_mux[ST_OP]   = (state_q != S_IDLE);
				rd_mux[ST_HALT] = cpu_halt;
				rd_mux[ST_FUSE] = fu_s2;
				rd_mux[ST_VEC+:15] = reset_vector;
			end
			default: rd_mux = 32'h0;
		endcase
	end

	// Read channels
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h0;
			rresp   <= RESP_OK;
		end
		else
		begin
			arready <= arvalid && !arready && !rvalid;
			if (rd_take)
			begin
				rvalid <= 1'b1;
				rdata  <= rd_mux;
				rresp  <= rd_resp;
			end
			else if (rready)
				rvalid <= 1'b0;
		end
	end

	// ****************************************
	// Pointer and data registers
	// ****************************************
	// Pointer and data writes
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ptr_q <= 16'h0;
			dat_q <= 16'h0;
		end
		else if (wr_take && awaddr == ADDR_PTR)
			ptr_q <= merge16(ptr_q, wdata, wstrb);
		else if (wr_take && awaddr == ADDR_DATA)
			dat_q <= merge16(dat_q, wdata, wstrb);
	end

	// ****************************************
	// Command decode
	// ****************************************
	assign cmd6    = {1'b0, cmd_q};
	assign go      = store_wr && (win_q != 3'h0) && (state_q == S_IDLE);
	assign op_done = (state_q != S_IDLE) && (tmr_q == 32'h1);
	assign permit  = in_boot(ptr_q[15:PAGE_LSB]) ? lock_q[4] : lock_q[2];
	assign ld_go   = go && !ee_s2 && (cmd6 == CMD_LOAD);
	assign wr_start = go && !ee_s2 && (cmd6 == CMD_WRIT) && permit;
	assign clr_buf = (op_done && state_q == S_WRITE) ||
		(go && !ee_s2 && cmd6 == CMD_REEN);

	// ****************************************
	// Sequencer
	// ****************************************
	// Control bits, store window, operations and lock bits
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_q <= S_IDLE;
			tmr_q   <= 32'h0;
			cmd_q   <= 5'h0;
			ie_q    <= 1'b0;
			busy_q  <= 1'b0;
			halt_q  <= 1'b0;
			win_q   <= 3'h0;
			page_q  <= 9'h0;
			lkdat_q <= LOCK_RST;
			lock_q  <= LOCK_RST;
		end
		else
		begin
			// Window countdown
			if (win_q != 3'h0)
				win_q <= win_q - 3'h1;
			// Control writes, command bits only while idle
			if (ctrl_wr)
			begin
				ie_q <= wdata[CB_IE];
				if (state_q == S_IDLE && win_q == 3'h0)
				begin
					cmd_q <= wdata[4:0];
					if (wdata[CB_EN])
						win_q <= STORE_WIN;
				end
			end
			if (win_q == 3'h1 && !go && state_q == S_IDLE)
				cmd_q <= 5'h0;
			// Store within the window
			if (go)
			begin
				win_q <= 3'h0;
				cmd_q <= 5'h0;
				if (!ee_s2)
				begin
					unique case (cmd6)
						CMD_ERAS, CMD_WRIT:
						begin
							if (permit)
							begin
								page_q  <= ptr_q[15:PAGE_LSB];
								halt_q  <= in_no_readwhilewrite_area(ptr_q[15:PAGE_LSB]);
								busy_q  <= 1'b1;
								tmr_q   <= PROG_CYCLES;
								state_q <= (cmd6 == CMD_ERAS) ? S_ERASE : S_WRITE;
								cmd_q   <= cmd_q;
							end
						end
						CMD_LOCK:
						begin
							lkdat_q <= dat_q[5:0];
							tmr_q   <= PROG_CYCLES;
							state_q <= S_LOCK;
							cmd_q   <= cmd_q;
						end
						CMD_REEN: busy_q <= 1'b0;
						default: cmd_q <= 5'h0;
					endcase
				end
			end
			// Operation timer
			if (state_q != S_IDLE)
				tmr_q <= tmr_q - 32'h1;
			if (op_done)
			begin
				state_q <= S_IDLE;
				halt_q  <= 1'b0;
				cmd_q   <= 5'h0;
				if (state_q == S_LOCK)
					lock_q <= lock_q & lkdat_q;
			end
			if (ce_s2)
				lock_q <= LOCK_RST;
		end
	end

	// ****************************************
	// Temporary page buffer
	// ****************************************
	// Random order word store
	always_ff @(posedge aclk)
	begin
		if (ld_go)
			buf_q[ptr_q[WORD_LSB+:WORD_W]] <= dat_q;
	end

	// Loaded flags
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			bval_q <= 64'h0;
		else if (clr_buf || ee_s2)
			bval_q <= 64'h0;
		else if (ld_go)
			bval_q[ptr_q[WORD_LSB+:WORD_W]] <= 1'b1;
	end

	// ****************************************
	// Flash array drive
	// ****************************************
	// Erase strobe and word stream of a page write
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			strm_q      <= 1'b0;
			idx_q       <= 6'h0;
			flash_wr    <= '0;
			flash_erase <= '0;
		end
		else
		begin
			flash_erase.en   <= go && !ee_s2 && (cmd6 == CMD_ERAS) && permit;
			flash_erase.page <= ptr_q[15:PAGE_LSB];
			if (wr_start)
			begin
				strm_q <= 1'b1;
				idx_q  <= 6'h0;
			end
			else if (strm_q)
			begin
				idx_q <= idx_q + 6'h1;
				if (idx_q == 6'h3F)
					strm_q <= 1'b0;
			end
			flash_wr.en   <= strm_q;
			flash_wr.addr <= {page_q, idx_q};
			flash_wr.data <= bval_q[idx_q] ? buf_q[idx_q] : ERASED;
		end
	end

	// ****************************************
	// Core side outputs
	// ****************************************
	// Vector, halt, read block and interrupt
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			reset_vector   <= APP_VEC;
			cpu_halt       <= 1'b0;
			rww_read_block <= 1'b0;
			spm_irq        <= 1'b0;
			flash_rd_addr  <= 15'h0;
		end
		else
		begin
			reset_vector   <= fu_s2 ? APP_VEC : BOOT_VEC;
			cpu_halt       <= halt_q && (state_q != S_IDLE);
			rww_read_block <= busy_q;
			spm_irq        <= ie_q && !cmd_q[CB_EN];
			flash_rd_addr  <= ptr_q[15:1];
		end
	end

endmodule

/* File: verif/fsh_chk.sv */
// Port checker for the flash self-programming sequencer.
// Holds for PROG_CYCLES of 64 or more; bound into every sequencer instance.
`timescale 1ns/1ns
module fsh_chk
	import fsh_pkg::*;
(
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Bus handshake
	input wire logic        awready,
	// Pins and flash array
	input wire logic        boot_vector_fuse,
	input wire fsh_wr_s     flash_wr,
	input wire fsh_er_s     flash_erase,
	// Core side
	input wire logic [14:0] reset_vector,
	input wire logic        cpu_halt,
	input wire logic        rww_read_block,
	input wire logic        spm_irq
);
	// ****************************************
	// Helper logic
	// ****************************************
	logic [6:0] run_q; // Length of the running write burst

	// Counts consecutive word strobes
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !flash_wr.en)
			run_q <= 7'h00;
		else
			run_q <= run_q + 7'h01;
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_vec_app: assert property (
		boot_vector_fuse [*6] |-> reset_vector == APP_VEC) else $error("vector not application start");
	a_vec_boot: assert property (
		(!boot_vector_fuse) [*6] |-> reset_vector == BOOT_VEC) else $error("vector not boot start");
	a_erase_pulse: assert property (
		flash_erase.en |=> !flash_erase.en) else $error("erase strobe longer than one cycle");
	a_halt_no_readwhilewrite_area: assert property (
		flash_erase.en && flash_erase.page >= NO_READWHILEWRITE_AREA_PAGE |-> ##[0:3] cpu_halt) else $error("no halt");
	a_nohalt_rww: assert property (
		flash_erase.en && flash_erase.page < NO_READWHILEWRITE_AREA_PAGE |-> !cpu_halt [*4]) else $error("halt on rww page");
	a_busy_block: assert property (
		flash_erase.en |-> ##[0:3] rww_read_block) else $error("area not blocked");
	a_busy_stays: assert property (
		$fell(rww_read_block) |-> $past(awready) || $past(awready, 2) || $past(awready, 3))
		else $error("busy cleared without a write");
	a_irq_quiet: assert property (
		flash_wr.en |-> !spm_irq) else $error("interrupt during operation");
	a_burst_len: assert property (
		$fell(flash_wr.en) |-> run_q == 7'h40) else $error("burst not one page");
	a_burst_base: assert property (
		$rose(flash_wr.en) |-> flash_wr.addr[5:0] == 6'h00) else $error("burst not at page start");
	a_word_step: assert property (
		flash_wr.en && $past(flash_wr.en) |-> flash_wr.addr == $past(flash_wr.addr) + 15'h0001)
		else $error("burst address not stepping");

	// Main scenarios reached
	c_no_readwhilewrite_area: cover property (flash_erase.en && flash_erase.page >= NO_READWHILEWRITE_AREA_PAGE);
	c_write: cover property ($fell(flash_wr.en));
	c_reen: cover property ($fell(rww_read_block));
endmodule

bind fsh_sequencer fsh_chk u_chk (.aclk, .aresetn, .awready, .boot_vector_fuse, .flash_wr, .flash_erase,
	.reset_vector, .cpu_halt, .rww_read_block, .spm_irq);

/* File: verif/fsh_flash_model.sv */
// Behavioural flash array beside the sequencer.
// Read data follows the address by one cycle; programming only clears bits.
`timescale 1ns/1ns
module fsh_flash_model
	import fsh_pkg::*;
(
	// Clock
	input wire logic        aclk,
	// Sequencer side
	input wire logic [14:0] rd_addr,
	input wire fsh_wr_s     wr,
	input wire fsh_er_s     er,
	output logic [15:0]     rd_data
);
	logic [15:0] mem [0:32767]; // Array contents
	int          er_cnt;        // Erases seen
	logic [8:0]  er_page;       // Last page erased

	// Non-blank start pattern so a skipped erase shows
	initial
	begin
		for (int i = 0; i < 32768; i++)
			mem[i] = i[15:0] ^ 16'hA5C3;
		er_cnt = 0;
		er_page = 9'h000;
		rd_data = 16'h0000;
	end

	// Read, program and erase
	always @(posedge aclk)
	begin
		rd_data <= mem[rd_addr];
		if (wr.en)
			mem[wr.addr] <= mem[wr.addr] & wr.data;
		if (er.en)
		begin
			for (int j = 0; j < PAGE_WORDS; j++)
				mem[{er.page, 6'h00} + j] <= ERASED;
			er_cnt++;
			er_page <= er.page;
		end
	end
endmodule

/* File: verif/tb.sv */
// Self-checking bench for the flash sequencer.
// Drives the register bus as a master; the flash model answers reads.
`timescale 1ns/1ns
module tb
	import fsh_pkg::*;
;
	// ****************************************
	// Signals
	// ****************************************
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  awaddr = 8'h00;
	logic [7:0]  araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        arvalid = 1'b0;
	logic        boot_vector_fuse = 1'b1;
	logic        eeprom_write_in_progress_flag = 1'b0;
	logic        chip_erase_req = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic [15:0] flash_rd_data;
	logic [14:0] flash_rd_addr, reset_vector;
	fsh_wr_s     flash_wr;
	fsh_er_s     flash_erase;
	logic        cpu_halt, rww_read_block, spm_irq;
	int          err_total = 0;
	int          n_compared = 0;
	logic [31:0] rd_v;      // Last read data
	logic [1:0]  rs_v;      // Last read response
	logic [1:0]  bs_v;      // Last write response
	logic        seen_halt; // Halt seen while polling

	// Design and flash array
	fsh_sequencer #(.PROG_CYCLES(80)) dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
		.wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready(1'b1), .araddr, .arvalid, .arready,
		.rdata, .rresp, .rvalid, .rready(1'b1), .boot_vector_fuse, .eeprom_write_in_progress_flag,
		.chip_erase_req, .flash_rd_data, .flash_rd_addr, .flash_wr, .flash_erase, .reset_vector,
		.cpu_halt, .rww_read_block, .spm_irq);
	fsh_flash_model fl (.aclk, .rd_addr(flash_rd_addr), .wr(flash_wr), .er(flash_erase), .rd_data(flash_rd_data));

	// 10 MHz clock
	always #50 aclk = ~aclk;

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic end_sim();
		$display("Compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic tmo();
		err_total++;
		$display("Error at %0t: wait ran out", $time);
		end_sim();
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			err_total++;
			$display("Error at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask

	// Bus write: address and data together, response awaited
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		int n;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		n = 0;
		do begin @(posedge aclk); n++; end while (awready !== 1'b1 && n < 50);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		while (bvalid !== 1'b1 && n < 50) begin @(posedge aclk); n++; end
		bs_v = bresp;
		if (n >= 50)
			tmo();
	endtask

	// Bus read into rd_v and rs_v
	task automatic axr(input logic [7:0] a);
		int n;
		araddr <= a;
		arvalid <= 1'b1;
		n = 0;
		do begin @(posedge aclk); n++; end while (arready !== 1'b1 && n < 50);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1 && n < 50) begin @(posedge aclk); n++; end
		if (n >= 50)
			tmo();
		rd_v = rdata;
		rs_v = rresp;
	endtask

	// Command pattern with interrupt enabled, then the store strobe
	task automatic cmd(input logic [5:0] c);
		axw(ADDR_CTRL, {24'h0, 2'b10, c});
		axw(ADDR_STORE, 32'h0);
	endtask

	// Poll until the command enable bit clears
	task automatic wait_done();
		int n;
		n = 0;
		do begin axr(ADDR_CTRL); n++; if (cpu_halt === 1'b1) seen_halt = 1'b1; end
		while (rd_v[CB_EN] !== 1'b0 && n < 100);
		if (n >= 100)
			tmo();
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_boot();
		chk(reset_vector, APP_VEC);
		boot_vector_fuse <= 1'b0;
		tick(6);
		chk(reset_vector, BOOT_VEC);
		axw(ADDR_STAT, 32'hFFFFFFFF);
		chk(bs_v, RESP_OK);
		axr(ADDR_STAT);
		chk(rd_v[ST_FUSE], 32'h0);
		chk(reset_vector, BOOT_VEC);
		axr(8'h1C);
		chk(rs_v, RESP_ERR);
		axw(8'h1C, 32'h0);
		chk(bs_v, RESP_ERR);
		boot_vector_fuse <= 1'b1;
		tick(6);
		chk(reset_vector, APP_VEC);
		$display("t_boot done");
	endtask

	task automatic t_page();
		int n;
		axw(ADDR_PTR, 32'h018A);
		axw(ADDR_DATA, 32'h1234);
		cmd(CMD_LOAD);
		axw(ADDR_PTR, 32'h0184);
		axw(ADDR_DATA, 32'hBEEF);
		cmd(CMD_LOAD);
		axw(ADDR_PTR, 32'h0180);
		n = fl.er_cnt;
		cmd(CMD_ERAS);
		wait_done();
		chk(fl.er_cnt, n + 1);
		chk(fl.er_page, 32'h3);
		cmd(CMD_WRIT);
		wait_done();
		chk(fl.mem[16'h00C5], 32'h1234);
		chk(fl.mem[16'h00C2], 32'hBEEF);
		chk(fl.mem[16'h00C0], ERASED);
		chk(spm_irq, 32'h1);
		chk(rd_v[CB_BUSY], 32'h1);
		axr(ADDR_READ);
		chk(rd_v[7:0], BLOCKED);
		cmd(CMD_REEN);
		axr(ADDR_CTRL);
		chk(rd_v[CB_BUSY], 32'h0);
		axw(ADDR_PTR, 32'h018B);
		axr(ADDR_READ);
		chk(rd_v[7:0], 32'h12);
		axw(ADDR_PTR, 32'h018A);
		axr(ADDR_READ);
		chk(rd_v[7:0], 32'h34);
		$display("t_page done");
	endtask

	task automatic t_eeprom();
		int n;
		axw(ADDR_PTR, 32'h020E);
		axw(ADDR_DATA, 32'h5555);
		cmd(CMD_LOAD);
		eeprom_write_in_progress_flag <= 1'b1;
		tick(6);
		eeprom_write_in_progress_flag <= 1'b0;
		tick(6);
		axr(ADDR_STAT);
		chk(rd_v[ST_EE], 32'h0);
		axw(ADDR_PTR, 32'h0200);
		cmd(CMD_ERAS);
		wait_done();
		cmd(CMD_WRIT);
		wait_done();
		chk(fl.mem[16'h0107], ERASED);
		chk(fl.mem[16'h0105], ERASED);
		cmd(CMD_REEN);
		eeprom_write_in_progress_flag <= 1'b1;
		tick(4);
		axr(ADDR_LOCK);
		chk(rs_v, RESP_ERR);
		n = fl.er_cnt;
		cmd(CMD_ERAS);
		tick(4);
		chk(fl.er_cnt, n);
		eeprom_write_in_progress_flag <= 1'b0;
		tick(4);
		$display("t_eeprom done");
	endtask

	task automatic t_halt();
		axw(ADDR_PTR, 32'hE000);
		cmd(CMD_ERAS);
		axw(ADDR_PTR, 32'h0180);
		seen_halt = 1'b0;
		wait_done();
		chk(seen_halt, 32'h1);
		chk(fl.er_page, 32'h1C0);
		cmd(CMD_REEN);
		$display("t_halt done");
	endtask

	task automatic t_nostore();
		int n;
		n = fl.er_cnt;
		axw(ADDR_CTRL, {24'h0, 2'b10, CMD_ERAS});
		tick(8);
		axr(ADDR_CTRL);
		chk(rd_v[5:0], 32'h0);
		axw(ADDR_STORE, 32'h0);
		tick(4);
		chk(fl.er_cnt, n);
		$display("t_nostore done");
	endtask

	task automatic t_lock();
		int n;
		axw(ADDR_PTR, 32'hE000);
		axw(ADDR_DATA, 32'h00FB);
		seen_halt = 1'b0;
		cmd(CMD_LOCK);
		wait_done();
		chk(rd_v[CB_BUSY], 32'h0);
		chk(seen_halt, 32'h0);
		axr(ADDR_LOCK);
		chk(rd_v[7:0], 32'hFB);
		axw(ADDR_DATA, 32'h00FF);
		cmd(CMD_LOCK);
		wait_done();
		axr(ADDR_LOCK);
		chk(rd_v[7:0], 32'hFB);
		axw(ADDR_PTR, 32'h0180);
		n = fl.er_cnt;
		cmd(CMD_ERAS);
		tick(4);
		chk(fl.er_cnt, n);
		chip_erase_req <= 1'b1;
		tick(3);
		chip_erase_req <= 1'b0;
		tick(2);
		axr(ADDR_LOCK);
		chk(rd_v[7:0], 32'hFF);
		$display("t_lock done");
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		tick(4);
		aresetn <= 1'b1;
		t_boot();
		t_page();
		t_eeprom();
		t_halt();
		t_nostore();
		t_lock();
		end_sim();
	end
endmodule
